// file: core/sfp_pkg.sv
package sfp_pkg;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS   = 20;
   localparam int RESTART_MIN_NS  = 1000;
   localparam int RESTART_MIN_CYC = (RESTART_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RESTART_CNT_W   = 7;

   // ---------------------------------------------------------------
   // Instruction codes and shape
   // ---------------------------------------------------------------
   localparam logic [7:0] OPC_DUAL_OUT = 8'h3B;
   localparam logic [7:0] OPC_DUAL_IO  = 8'hBB;
   localparam logic [7:0] OPC_QUAD_OUT = 8'h6B;
   localparam logic [7:0] OPC_QUAD_IO  = 8'hEB;
   localparam logic [3:0] BYTE_BITS    = 4'h8;
   localparam int         LANES        = 4;

   // Lane width codes: bits moved per serial clock edge
   localparam logic [3:0] WIDTH_ONE  = 4'h1;
   localparam logic [3:0] WIDTH_TWO  = 4'h2;
   localparam logic [3:0] WIDTH_FOUR = 4'h4;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      SFP_ST_IDLE = 2'b00,
      SFP_ST_OPC  = 2'b01,
      SFP_ST_BODY = 2'b10,
      SFP_ST_SKIP = 2'b11
   } sfp_state_e;

   // Pins as seen by the device
   typedef struct packed {
      logic             cs_b;
      logic             sck;
      logic             restart_b;
      logic [LANES-1:0] lane_in;
   } sfp_pins_s;

   // Lane drive toward the pins
   typedef struct packed {
      logic [LANES-1:0] lane_out;
      logic [LANES-1:0] lane_oe;
   } sfp_drive_s;

endpackage

// file: core/sfp_sync.sv
// -------------------------------------------------------------------
// Two-stage synchroniser with constant reset value
// -------------------------------------------------------------------
module sfp_sync #(
   parameter int              W       = 1,
   parameter logic [W-1:0]    RST_VAL = '0
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst_b,
   // Data
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta_reg;
   logic [W-1:0] q_reg;

   // First stage feeds only the second
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         meta_reg <= RST_VAL;
         q_reg    <= RST_VAL;
      end else begin
         meta_reg <= d;
         q_reg    <= meta_reg;
      end
   end

   assign q = q_reg;

endmodule // sfp_sync

// file: core/sfp_pin_if.sv
// Operation
// - Chip select high: deselected, lanes tri-stated
// - Accept instructions only after first select fall
// - Standard mode samples input on rising edge
// - Standard mode drives output on falling edge
// - Multi-lane: capture rising, drive falling
// - Quad only with enable; guard, pause become lanes
// - Guard low plus hardware policy blocks status write
// - Pause low: tri-state, ignore clock, then resume; the lanes of a byte being sent stay undriven until the next byte loads
// - Four-lane enable disables pause function
// - Guard and pause act only outside quad
// - Restart held one microsecond resets everything
// - Restart works in any state
// - Works with clock mode 0 or 3
// - Dual instructions use lanes zero and one
// - Quad instructions use lanes zero to three
// - Internal cycle survives chip select rise
module sfp_pin_if
   import sfp_pkg::*;
#(
   parameter logic [7:0] OPC_WRITE_STATUS = 8'h01
) (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_b,
   // Serial pins
   input  sfp_pins_s       pins,
   output sfp_drive_s      drive,
   // Configuration from the status store
   input  wire logic       four_lane_enable,
   input  wire logic       status_lock_policy,
   // Transmit side
   input  wire logic       tx_valid,
   input  wire logic [7:0] tx_byte,
   output logic            tx_take,
   // Receive side
   output logic            opc_valid,
   output logic [7:0]      opc_byte,
   output logic            rx_valid,
   output logic [7:0]      rx_byte,
   // Frame and status
   output logic            frame_end,
   output logic            frame_abort,
   output logic            status_write_block,
   output logic            pause_active,
   output logic            dev_restart
);

   // ---------------------------------------------------------------
   // Pin synchronisers and serial clock edges
   // ---------------------------------------------------------------
   sfp_pins_s pins_s;
   logic      sck_prev_reg;
   logic      cs_prev_reg;
   logic      sck_rise;
   logic      sck_fall;
   logic      cs_fall;
   logic      cs_rise;

   sfp_sync #(.W(3), .RST_VAL(3'b111)) u_sync_ctl (
      .clk   (clk),
      .rst_b (rst_b),
      .d     ({pins.cs_b, pins.sck, pins.restart_b}),
      .q     ({pins_s.cs_b, pins_s.sck, pins_s.restart_b})
   );

   sfp_sync #(.W(LANES), .RST_VAL(4'hF)) u_sync_lane (
      .clk   (clk),
      .rst_b (rst_b),
      .d     (pins.lane_in),
      .q     (pins_s.lane_in)
   );

   // Edge detection on the synchronised copies, both clock modes alike
   assign sck_rise = pins_s.sck & ~sck_prev_reg;
   assign sck_fall = ~pins_s.sck & sck_prev_reg;
   assign cs_fall  = ~pins_s.cs_b & cs_prev_reg;
   assign cs_rise  = pins_s.cs_b & ~cs_prev_reg;

   // ---------------------------------------------------------------
   // Restart pin qualification
   // ---------------------------------------------------------------
   logic [RESTART_CNT_W-1:0] rst_cnt_reg;
   logic [RESTART_CNT_W-1:0] rst_cnt_next;
   logic                     restart_reg;
   logic                     restart_next;
   logic                     soft_rst;

   // Short glitches never restart; a full width low does, in any state
   always_comb begin
      rst_cnt_next = rst_cnt_reg;
      restart_next = 1'b0;
      if (pins_s.restart_b) begin
         rst_cnt_next = '0;
      end else if (rst_cnt_reg != RESTART_CNT_W'(RESTART_MIN_CYC)) begin
         rst_cnt_next = rst_cnt_reg + 1'b1;
         restart_next = (rst_cnt_reg == RESTART_CNT_W'(RESTART_MIN_CYC - 1));
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         rst_cnt_reg <= '0;
         restart_reg <= 1'b0;
      end else begin
         rst_cnt_reg <= rst_cnt_next;
         restart_reg <= restart_next;
      end
   end

   // Restart has priority over every other pin
   assign soft_rst = restart_reg;

   // ---------------------------------------------------------------
   // Frame engine
   // ---------------------------------------------------------------
   sfp_state_e       st_reg,       st_next;
   logic [3:0]       cnt_reg,      cnt_next;
   logic [7:0]       sh_reg,       sh_next;
   logic [7:0]       opc_reg,      opc_next;
   logic [3:0]       in_w_reg,     in_w_next;
   logic [3:0]       out_w_reg,    out_w_next;
   logic             tx_mode_reg,  tx_mode_next;
   logic             armed_reg,    armed_next;
   logic             opc_v_reg,    opc_v_next;
   logic             rx_v_reg,     rx_v_next;
   logic [7:0]       rx_b_reg,     rx_b_next;
   logic             take_reg,     take_next;
   logic             end_reg,      end_next;
   logic             abort_reg,    abort_next;
   logic             swb_reg,      swb_next;
   logic             pause_reg,    pause_next;
   logic [LANES-1:0] lout_reg,     lout_next;
   logic [LANES-1:0] loe_reg,      loe_next;
   logic             quad_now;
   logic             pause_hit;
   logic             guard_low;
   logic [3:0]       cur_w;
   logic [3:0]       cnt_sum;
   logic [7:0]       in_bits;
   logic [7:0]       ld_byte;

   // Quad use of the shared pins removes their guard and pause role
   assign quad_now  = (in_w_reg == WIDTH_FOUR) | (out_w_reg == WIDTH_FOUR);
   assign pause_hit = ~pins_s.cs_b & ~pins_s.lane_in[3] & ~four_lane_enable & ~quad_now;
   assign guard_low = ~pins_s.lane_in[2] & ~four_lane_enable & ~quad_now;
   assign cur_w     = tx_mode_reg ? out_w_reg : in_w_reg;
   assign cnt_sum   = cnt_reg + cur_w;

   // Lanes gathered most significant bit first per edge
   always_comb begin
      in_bits = '0;
      unique case (in_w_reg)
         WIDTH_FOUR: in_bits = {sh_reg[3:0], pins_s.lane_in};
         WIDTH_TWO:  in_bits = {sh_reg[5:0], pins_s.lane_in[1:0]};
         default:    in_bits = {sh_reg[6:0], pins_s.lane_in[0]};
      endcase
   end

   always_comb begin
      st_next      = st_reg;
      cnt_next     = cnt_reg;
      sh_next      = sh_reg;
      opc_next     = opc_reg;
      in_w_next    = in_w_reg;
      out_w_next   = out_w_reg;
      tx_mode_next = tx_mode_reg;
      armed_next   = armed_reg;
      opc_v_next   = 1'b0;
      rx_v_next    = 1'b0;
      rx_b_next    = rx_b_reg;
      take_next    = 1'b0;
      end_next     = 1'b0;
      abort_next   = 1'b0;
      swb_next     = swb_reg;
      pause_next   = pause_hit;
      lout_next    = lout_reg;
      loe_next     = loe_reg;
      ld_byte      = tx_byte;

      if (cs_fall) begin
         armed_next = 1'b1;
      end

      if (pins_s.cs_b) begin
         // Deselected: lanes released, frame dropped
         loe_next     = '0;
         tx_mode_next = 1'b0;
         in_w_next    = WIDTH_ONE;
         out_w_next   = WIDTH_ONE;
         cnt_next     = '0;
         swb_next     = 1'b0;
         if (cs_rise && st_reg != SFP_ST_IDLE) begin
            end_next   = 1'b1;
            // A partial byte means the transaction is thrown away
            abort_next = ((cnt_reg != 4'h0) & ~(tx_mode_reg & (cnt_reg == BYTE_BITS))) |
                         (st_reg == SFP_ST_OPC);
         end
         // Internal cycles run on elsewhere; nothing here stops them
         st_next = SFP_ST_IDLE;
      end else if (pause_hit) begin
         // Paused: outputs floated, clock and input ignored, state kept
         loe_next = '0;
      end else begin
         if (st_reg == SFP_ST_IDLE && cs_fall && armed_next) begin
            st_next = SFP_ST_OPC;
         end
         // Drive stays off unless transmitting on the current lanes
         if (!tx_mode_reg) begin
            loe_next = '0;
         end

         // Rising edge: sample the input lanes
         if (sck_rise && !tx_mode_reg &&
             (st_reg == SFP_ST_OPC || st_reg == SFP_ST_BODY)) begin
            sh_next  = in_bits;
            cnt_next = cnt_sum;
            if (cnt_sum == BYTE_BITS) begin
               cnt_next = '0;
               if (st_reg == SFP_ST_OPC) begin
                  opc_next   = in_bits;
                  opc_v_next = 1'b1;
                  st_next    = SFP_ST_BODY;
                  unique case (in_bits)
                     OPC_DUAL_OUT: out_w_next = WIDTH_TWO;
                     OPC_DUAL_IO: begin
                        in_w_next  = WIDTH_TWO;
                        out_w_next = WIDTH_TWO;
                     end
                     OPC_QUAD_OUT, OPC_QUAD_IO: begin
                        if (four_lane_enable) begin
                           out_w_next = WIDTH_FOUR;
                           in_w_next  = (in_bits == OPC_QUAD_IO) ? WIDTH_FOUR : WIDTH_ONE;
                        end else begin
                           opc_v_next = 1'b0;
                           st_next    = SFP_ST_SKIP;
                        end
                     end
                     default: begin
                        in_w_next  = WIDTH_ONE;
                        out_w_next = WIDTH_ONE;
                     end
                  endcase
                  // Guard pin sampled with the code it protects
                  if (in_bits == OPC_WRITE_STATUS) begin
                     swb_next = guard_low & status_lock_policy;
                  end
               end else begin
                  rx_b_next = in_bits;
                  rx_v_next = 1'b1;
               end
            end
         end

         // Falling edge: present the next lane group
         if (sck_fall && st_reg == SFP_ST_BODY) begin
            if (tx_mode_reg && cnt_reg != BYTE_BITS) begin
               // Next group of the byte in flight; the count holds bits already shown
               cnt_next = cnt_sum;
               sh_next  = sh_reg << out_w_reg;
               unique case (out_w_reg)
                  WIDTH_FOUR: lout_next      = sh_reg[7:4];
                  WIDTH_TWO:  lout_next[1:0] = sh_reg[7:6];
                  default:    lout_next[1]   = sh_reg[7];
               endcase
            end else begin
               if (tx_mode_reg) begin
                  // Last group has had its full phase: release unless reloaded
                  cnt_next     = '0;
                  tx_mode_next = 1'b0;
                  loe_next     = '0;
               end
               if (cnt_next == 4'h0 && tx_valid) begin
               // Load a fresh byte and put its first group out at once
               take_next    = 1'b1;
               tx_mode_next = 1'b1;
               cnt_next     = out_w_reg;
               sh_next      = ld_byte << out_w_reg;
               lout_next    = '0;
               loe_next     = '0;
               unique case (out_w_reg)
                  WIDTH_FOUR: begin
                     lout_next = ld_byte[7:4];
                     loe_next  = 4'hF;
                  end
                  WIDTH_TWO: begin
                     lout_next[1:0] = ld_byte[7:6];
                     loe_next[1:0]  = 2'h3;
                  end
                  default: begin
                     lout_next[1] = ld_byte[7];
                     loe_next[1]  = 1'b1;
                  end
               endcase
               end
            end
         end
      end
   end

   // Restart returns every bit to its power-on value
   always_ff @(posedge clk) begin
      if (!rst_b || soft_rst) begin
         st_reg       <= SFP_ST_IDLE;
         cnt_reg      <= '0;
         sh_reg       <= '0;
         opc_reg      <= '0;
         in_w_reg     <= WIDTH_ONE;
         out_w_reg    <= WIDTH_ONE;
         tx_mode_reg  <= 1'b0;
         armed_reg    <= 1'b0;
         opc_v_reg    <= 1'b0;
         rx_v_reg     <= 1'b0;
         rx_b_reg     <= '0;
         take_reg     <= 1'b0;
         end_reg      <= 1'b0;
         abort_reg    <= 1'b0;
         swb_reg      <= 1'b0;
         pause_reg    <= 1'b0;
         lout_reg     <= '0;
         loe_reg      <= '0;
         sck_prev_reg <= 1'b0;
         // Low so a select already low at restart is not taken as a fresh fall
         cs_prev_reg  <= 1'b0;
      end else begin
         st_reg       <= st_next;
         cnt_reg      <= cnt_next;
         sh_reg       <= sh_next;
         opc_reg      <= opc_next;
         in_w_reg     <= in_w_next;
         out_w_reg    <= out_w_next;
         tx_mode_reg  <= tx_mode_next;
         armed_reg    <= armed_next;
         opc_v_reg    <= opc_v_next;
         rx_v_reg     <= rx_v_next;
         rx_b_reg     <= rx_b_next;
         take_reg     <= take_next;
         end_reg      <= end_next;
         abort_reg    <= abort_next;
         swb_reg      <= swb_next;
         pause_reg    <= pause_next;
         lout_reg     <= lout_next;
         loe_reg      <= loe_next;
         sck_prev_reg <= pins_s.sck;
         cs_prev_reg  <= pins_s.cs_b;
      end
   end

   // ---------------------------------------------------------------
   // Outputs, all straight from flip-flops
   // ---------------------------------------------------------------
   assign drive.lane_out      = lout_reg;
   assign drive.lane_oe       = loe_reg;
   assign tx_take             = take_reg;
   assign opc_valid           = opc_v_reg;
   assign opc_byte            = opc_reg;
   assign rx_valid            = rx_v_reg;
   assign rx_byte             = rx_b_reg;
   assign frame_end           = end_reg;
   assign frame_abort         = abort_reg;
   assign status_write_block  = swb_reg;
   assign pause_active        = pause_reg;
   assign dev_restart         = restart_reg;

endmodule // sfp_pin_if

// file: tb/sfp_pin_if_asserts.sv
// ---------------------------------------------------------------
// Pin interface checker
// ---------------------------------------------------------------
module sfp_pin_if_asserts
   import sfp_pkg::*;
#(
   parameter logic [7:0] OPC_WRITE_STATUS = 8'h01
) (
   // Clock and reset
   input wire logic       clk,
   input wire logic       rst_b,
   // Pins
   input sfp_pins_s       pins,
   input sfp_drive_s      drive,
   // Configuration
   input wire logic       four_lane_enable,
   input wire logic       status_lock_policy,
   // Results
   input wire logic       opc_valid,
   input wire logic [7:0] opc_byte,
   input wire logic       frame_end,
   input wire logic       frame_abort,
   input wire logic       status_write_block,
   input wire logic       pause_active,
   input wire logic       dev_restart
);
   logic [7:0] low_reg;
   logic [7:0] low_next;

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);

   // Run length of the restart pin low, saturating
   always_comb begin
      low_next = pins.restart_b ? 8'h00 : ((low_reg == 8'hFF) ? low_reg : low_reg + 8'h01);
   end

   // Register the run length
   always_ff @(posedge clk) begin
      low_reg <= rst_b ? low_next : 8'h00;
   end

   // Margin of four cycles allows for the pin synchroniser
   a_cs_high_quiet: assert property (pins.cs_b [*6] |-> drive.lane_oe == 4'h0)
      else $error("lanes driven while deselected");
   a_restart_long: assert property (dev_restart |-> $past(low_reg, 4) >= 8'h2E)
      else $error("restart on a short pulse");
   a_restart_state: assert property (dev_restart |-> ##[1:2] (drive.lane_oe == 4'h0 && !status_write_block))
      else $error("state kept after restart");
   a_quad_refused: assert property (opc_valid && !four_lane_enable |-> opc_byte != OPC_QUAD_OUT && opc_byte != OPC_QUAD_IO)
      else $error("quad opcode taken while disabled");
   a_upper_lanes: assert property (drive.lane_oe[3:2] != 2'b00 |-> four_lane_enable)
      else $error("upper lanes driven without enable");
   a_guard_block: assert property ($rose(status_write_block) |-> status_lock_policy && opc_byte == OPC_WRITE_STATUS)
      else $error("block set without cause");
   a_block_clears: assert property (pins.cs_b [*6] |-> !status_write_block)
      else $error("block kept while deselected");
   a_pause_quad: assert property (four_lane_enable [*3] |-> !pause_active)
      else $error("pause while four lanes enabled");
   a_pause_hiz: assert property (pause_active [*2] |-> drive.lane_oe == 4'h0)
      else $error("lanes driven in pause");
   a_abort_end: assert property (frame_abort |-> frame_end)
      else $error("abort without frame end");
endmodule // sfp_pin_if_asserts

bind sfp_pin_if sfp_pin_if_asserts #(.OPC_WRITE_STATUS(OPC_WRITE_STATUS)) u_chk (
   .clk(clk), .rst_b(rst_b), .pins(pins), .drive(drive), .four_lane_enable(four_lane_enable),
   .status_lock_policy(status_lock_policy), .opc_valid(opc_valid), .opc_byte(opc_byte),
   .frame_end(frame_end), .frame_abort(frame_abort), .status_write_block(status_write_block),
   .pause_active(pause_active), .dev_restart(dev_restart)
);

// file: tb/sfp_mst.sv
// ---------------------------------------------------------------
// Bus master model, clock mode 0 or 3, half period 8 cycles
// ---------------------------------------------------------------
module sfp_mst
   import sfp_pkg::*;
(
   // Device pins
   output sfp_pins_s  pins,
   input  sfp_drive_s drive
);
   timeunit 1ns;
   timeprecision 1ns;

   logic       mode3     = 1'h0;
   logic       cs_b      = 1'h1;
   logic       sck       = 1'h0;
   logic       restart_b = 1'h1;
   logic [3:0] m_out     = 4'hF; // Guard and pause rest high

   // Device wins on its enabled lanes, master level elsewhere
   assign pins = {cs_b, sck, restart_b, (drive.lane_oe & drive.lane_out) | (~drive.lane_oe & m_out)};

   // Select with the clock at its idle level
   task automatic start(input logic m3);
      mode3 = m3;
      sck = m3;
      #160;
      cs_b = 1'h0;
      #160;
   endtask

   // Drive on the fall, sample on the rise, top bit first
   task automatic xfer(input int w, input int n, input logic [7:0] d, input logic rd, output logic [7:0] q);
      q = 8'h00;
      repeat (n) begin
         sck = 1'h0;
         // On a read lanes 0 to w-1 toggle so a stale level never passes; a one-lane read samples lane 1, which rests high
         for (int j = 0; j < w; j++) m_out[j] = rd ? ~m_out[j] : d[8 - w + j];
         d = d << w;
         #160;
         sck = 1'h1;
         for (int j = w - 1; j >= 0; j--) q = {q[6:0], pins.lane_in[(w == 1) ? 1 : j]};
         #160;
      end
   endtask

   // Deselect; mode 3 leaves the clock high
   task automatic stop();
      if (!mode3) sck = 1'h0;
      #160;
      cs_b = 1'h1;
      m_out = 4'hF;
      #200;
   endtask

   // Restart held for 60 cycles, above the 1 us minimum
   task automatic restart();
      restart_b = 1'h0;
      #1200;
      restart_b = 1'h1;
      #200;
   endtask
endmodule // sfp_mst

// file: tb/test_serial_flash_pin_interface.sv
module test_serial_flash_pin_interface;
   import sfp_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;

   typedef struct {
      logic [7:0] opc;
      logic       qe;
      logic       m3;
      logic       rd;
      int         w;
      logic [7:0] d;
      logic       ok;
   } sfp_row_s;

   localparam logic [7:0] WR_STATUS = 8'h01;

   logic       clk = 1'h0;
   logic       rst_b = 1'h0;
   logic       four_lane_enable = 1'h0;
   logic       status_lock_policy = 1'h0;
   logic       tx_valid = 1'h0;
   logic [7:0] tx_byte = 8'h00;
   sfp_pins_s  pins;
   sfp_drive_s drive;
   logic       tx_take, opc_valid, rx_valid, frame_end, frame_abort, status_write_block, pause_active, dev_restart;
   logic [7:0] opc_byte, rx_byte, q;
   logic       opc_seen, take_seen, abort_seen, rst_seen, pause_seen;
   int         num_errors = 0;
   int         checks_done = 0;
   sfp_row_s   rows [7] = '{
      '{8'h03, 1'h0, 1'h0, 1'h1, 1, 8'hA5, 1'h1},
      '{8'h02, 1'h0, 1'h1, 1'h0, 1, 8'h3C, 1'h1},
      '{OPC_DUAL_OUT, 1'h0, 1'h0, 1'h1, 2, 8'h96, 1'h1},
      '{OPC_DUAL_IO, 1'h0, 1'h1, 1'h0, 2, 8'h5A, 1'h1},
      '{OPC_QUAD_OUT, 1'h1, 1'h0, 1'h1, 4, 8'hC3, 1'h1},
      '{OPC_QUAD_IO, 1'h1, 1'h1, 1'h0, 4, 8'h81, 1'h1},
      '{OPC_QUAD_OUT, 1'h0, 1'h0, 1'h1, 4, 8'h7E, 1'h0}};

   sfp_pin_if #(.OPC_WRITE_STATUS(WR_STATUS)) u_sfp_pin_if (
      .clk(clk), .rst_b(rst_b), .pins(pins), .drive(drive), .four_lane_enable(four_lane_enable),
      .status_lock_policy(status_lock_policy), .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_take(tx_take),
      .opc_valid(opc_valid), .opc_byte(opc_byte), .rx_valid(rx_valid), .rx_byte(rx_byte),
      .frame_end(frame_end), .frame_abort(frame_abort), .status_write_block(status_write_block),
      .pause_active(pause_active), .dev_restart(dev_restart));

   sfp_mst u_sfp_mst (.pins(pins), .drive(drive));

   // Clock
   initial begin
      forever #10 clk = ~clk;
   end

   // Pulses are one cycle wide, pause_active as long as the pause, so hold them until checked
   always @(posedge clk) begin
      if (opc_valid) opc_seen <= 1'h1;
      if (tx_take) take_seen <= 1'h1;
      if (frame_abort) abort_seen <= 1'h1;
      if (dev_restart) rst_seen <= 1'h1;
      if (pause_active) pause_seen <= 1'h1;
   end

   // One byte offered per read
   always @(negedge clk) begin
      if (tx_take) tx_valid = 1'h0;
   end

   task automatic clr();
      {opc_seen, take_seen, abort_seen, rst_seen, pause_seen} = 5'h00;
   endtask

   task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e) begin
         num_errors++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic chk_flag(input string n, input logic e, input logic g);
      chk_byte(n, {7'h00, e}, {7'h00, g});
   endtask

   task automatic complete_run();
      $display("Checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Watchdog: the run needs about 63 us
   initial begin
      #400000;
      num_errors++;
      complete_run();
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      sfp_row_s r;
      clr();
      repeat (10) @(negedge clk);
      chk_flag("opc_valid", 1'h0, opc_valid);
      repeat (10) @(negedge clk);
      rst_b = 1'h1;
      repeat (5) @(negedge clk);
      foreach (rows[i]) begin
         r = rows[i];
         four_lane_enable = r.qe;
         tx_byte = r.d;
         tx_valid = r.rd;
         clr();
         u_sfp_mst.start(r.m3);
         u_sfp_mst.xfer(1, 8, r.opc, 1'h0, q);
         u_sfp_mst.xfer(r.w, 8 / r.w, r.d, r.rd, q);
         u_sfp_mst.stop();
         tx_valid = 1'h0;
         chk_flag("opc_valid", r.ok, opc_seen);
         if (r.ok) chk_byte("opc_byte", r.opc, opc_byte);
         if (r.rd) chk_flag("tx_take", r.ok, take_seen);
         if (r.rd && r.ok) chk_byte("read", r.d, q);
         if (!r.rd) chk_byte("rx_byte", r.d, rx_byte);
         chk_byte("lane_oe", 8'h00, {4'h0, drive.lane_oe});
      end
      // Pause in mid-opcode; with four lanes it is plain data
      for (int k = 0; k < 2; k++) begin
         four_lane_enable = k[0];
         clr();
         u_sfp_mst.start(1'h0);
         u_sfp_mst.xfer(1, 4, 8'h9F, 1'h0, q);
         u_sfp_mst.m_out[3] = 1'h0;
         u_sfp_mst.xfer(1, 4, 8'h00, 1'h0, q);
         u_sfp_mst.m_out[3] = 1'h1;
         u_sfp_mst.xfer(1, 4, 8'hF0, 1'h0, q);
         u_sfp_mst.stop();
         chk_flag("pause_active", !k[0], pause_seen);
         chk_byte("opc_byte", k[0] ? 8'h90 : 8'h9F, opc_byte);
      end
      four_lane_enable = 1'h0;
      // Deselect after half an opcode
      clr();
      u_sfp_mst.start(1'h0);
      u_sfp_mst.xfer(1, 4, WR_STATUS, 1'h0, q);
      u_sfp_mst.stop();
      chk_flag("frame_abort", 1'h1, abort_seen);
      chk_flag("opc_valid", 1'h0, opc_seen);
      // Guard low with hardware policy, software policy, guard high
      for (int k = 0; k < 3; k++) begin
         status_lock_policy = (k != 1);
         u_sfp_mst.m_out[2] = (k == 2);
         u_sfp_mst.start(1'h0);
         u_sfp_mst.xfer(1, 8, WR_STATUS, 1'h0, q);
         chk_flag("status_write_block", k == 0, status_write_block);
         u_sfp_mst.stop();
         chk_flag("status_write_block", 1'h0, status_write_block);
      end
      // Restart mid-frame; the select must fall again before an opcode
      clr();
      u_sfp_mst.start(1'h0);
      u_sfp_mst.xfer(1, 4, 8'h06, 1'h0, q);
      u_sfp_mst.restart();
      u_sfp_mst.xfer(1, 8, 8'h06, 1'h0, q);
      chk_flag("dev_restart", 1'h1, rst_seen);
      chk_flag("opc_valid", 1'h0, opc_seen);
      u_sfp_mst.stop();
      u_sfp_mst.start(1'h0);
      u_sfp_mst.xfer(1, 8, 8'h06, 1'h0, q);
      u_sfp_mst.stop();
      chk_flag("opc_valid", 1'h1, opc_seen);
      complete_run();
   end
endmodule // test_serial_flash_pin_interface
